//--- rtl/jms_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module jms_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             sys_clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage and pointers
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q        <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // jms_fifo

//--- rtl/jms_map.vh
// Constants for the compression mode sequencer: mode codes, markers,
// marker-enable bit positions, reset values.
// Assumes inclusion by bare name from the sequencer and bench files.
`ifndef JMS_MAP_VH
`define JMS_MAP_VH

// Mode register codes
`define JMS_MODE_COMP      4'h0
`define JMS_MODE_AUTO_BRC  4'h1
`define JMS_MODE_STAT      4'h2
`define JMS_MODE_COMP_BRC  4'h3
`define JMS_MODE_TABLES    4'h4
`define JMS_MODE_PRE_ENC   4'h5
`define JMS_MODE_EXPAND    4'h8
`define JMS_MODE_PREVIEW   4'h9
`define JMS_MODE_PRE_DEC   4'hA

// Frame markers
`define JMS_SOF_BASE       16'hFFC0
`define JMS_SOF_LOSSLESS   16'hFFC3

// Marker enable bit positions
`define JMS_EN_APP         0
`define JMS_EN_COM         1
`define JMS_EN_DRI         2
`define JMS_EN_DQT         3
`define JMS_EN_DHT         4
`define JMS_EN_PRELOAD_QUANT_TABLES        5
`define JMS_EN_PRELOAD_HUFFMAN_TABLES        6

// Segment codes put into the output stream
`define JMS_SEG_SOI        3'h0
`define JMS_SEG_APP        3'h1
`define JMS_SEG_COM        3'h2
`define JMS_SEG_DRI        3'h3
`define JMS_SEG_DQT        3'h4
`define JMS_SEG_DHT        3'h5
`define JMS_SEG_SOF        3'h6
`define JMS_SEG_EOI        3'h7

// Reset value, lossless precision limits, FIFO depth
`define JMS_SF_RESET       16'h0100
`define JMS_LOSSLESS_MAXP  4'hC
`define JMS_LOSSLESS_MINP  4'h2
`define JMS_FIFO_DEPTH     4

`endif

//--- rtl/jms_sequencer.v
// Mode sequencer: decodes the mode, picks baseline or lossless, emits segment codes.
// Assumes a launch is a host write to internal-memory address zero.
`timescale 1ns/100ps
`include "jms_map.vh"

// Operation
// - Mode register selects one of nine operations: six encode, three decode.
// - Marker FFC0 selects baseline, FFC3 selects lossless; source depends on direction.
// - Rate control, statistical pass and preview are baseline only; a lossless marker in preview is not rejected.
// - Compression emits compulsory segments plus enabled optional segments.
// - Enabled DQT scales stored tables by scale factor and emits them.
// - Compression ends by writing a new scale factor; host may override.
// - Statistical pass encodes without code output, accumulating volume and activity.
// - Statistical pass ends writing scale, allocation, volume and activity.
// - Rate-controlled pass budgets each block from activity and allocation factor.
// - Block code truncates beyond budget or maximum block volume.
// - Auto rate control: statistical pass then rate-controlled pass, rescaling tables.
// - Tables-only pass emits SOI, enabled tables, APP, COM, EOI; no pixels.
// - Encode preload loads scaled quant and encoder Huffman tables; interfaces idle.
// - Decode preload loads tables per preload bits; interfaces idle.
// - Lossless compression bypasses transform and quantization, two Huffman tables.
// - Lossless supports precision 2 to 12 bits and horizontal subsampling.
// - Lossless ignores point transform, treating it as zero.
// - Expansion copies segments to memory and decodes tables into stores.
// - A repeated segment type overwrites the stored one.
// - Preview decodes DC only, level-shifts, one sample per block.
// - Lossless marker in expansion selects lossless decoding.
// - Write to internal-memory address zero launches an operation.
// - Direction change invalidates Huffman store; quant store stays valid.
module jms_sequencer #(
  parameter SFW = 16,
  parameter CVW = 24
) (
  input  wire           sys_clk,
  input  wire           rstn,
  input  wire [3:0]     mode,
  input  wire           go_wr,
  input  wire [SFW-1:0] host_sf_data,
  input  wire           host_sf_wr,
  input  wire [15:0]    mem_frame_marker,
  input  wire [15:0]    in_frame_marker,
  input  wire           in_marker_valid,
  input  wire [6:0]     markers_en,
  input  wire [3:0]     sample_precision,
  input  wire [3:0]     scan_point_transform,
  input  wire [CVW-1:0] target_code_volume,
  input  wire [CVW-1:0] max_block_code_volume,
  input  wire           block_done,
  input  wire [15:0]    block_activity,
  input  wire [15:0]    block_bits,
  input  wire           image_done,
  input  wire           seg_in_valid,
  input  wire [2:0]     seg_in_type,
  output wire [2:0]     seg_out_data,
  output wire           seg_out_valid,
  input  wire           seg_out_ready,
  output reg            busy,
  output reg            lossless,
  output reg            bad_mode,
  output reg            pixel_active,
  output reg            code_active,
  output reg            dct_bypass,
  output reg            quant_bypass,
  output reg            dc_only,
  output reg  [3:0]     point_transform,
  output reg            huff_valid,
  output reg            huff_enc_fmt,
  output reg            quant_load,
  output reg            huff_load,
  output reg            seg_store_wr,
  output reg  [2:0]     seg_store_type,
  output reg            block_truncate,
  output reg  [15:0]    block_budget,
  output reg  [SFW-1:0] scale_factor_reg,
  output reg  [SFW-1:0] allocation_factor_reg,
  output reg  [CVW-1:0] accumulated_code_volume,
  output reg  [CVW-1:0] total_activity_measure
);
  // ------
  // States and helpers
  // ------
  localparam S_IDLE  = 3'd0;
  localparam S_FRAME = 3'd1;
  localparam S_HDR   = 3'd2;
  localparam S_STAT  = 3'd3;
  localparam S_CODE  = 3'd4;
  localparam S_TRAIL = 3'd5;
  localparam S_LOAD  = 3'd6;
  localparam S_EXP   = 3'd7;

  // Decodes a mode code into its class: 0 encode, 1 decode, 2 invalid
  function [1:0] mode_class;
    input [3:0] m;
    begin
      case (m)
        `JMS_MODE_COMP, `JMS_MODE_AUTO_BRC, `JMS_MODE_STAT,
        `JMS_MODE_COMP_BRC, `JMS_MODE_TABLES, `JMS_MODE_PRE_ENC: mode_class = 2'd0;
        `JMS_MODE_EXPAND, `JMS_MODE_PREVIEW, `JMS_MODE_PRE_DEC: mode_class = 2'd1;
        default: mode_class = 2'd2;
      endcase
    end
  endfunction

  // Baseline-only modes
  function base_only;
    input [3:0] m;
    begin
      base_only = (m == `JMS_MODE_AUTO_BRC) || (m == `JMS_MODE_STAT) ||
                  (m == `JMS_MODE_COMP_BRC) || (m == `JMS_MODE_PREVIEW);
    end
  endfunction

  reg  [2:0]     st_q;
  reg  [3:0]     op_q;
  reg            rate_ctl_q;
  reg            dir_dec_q;
  reg            dir_known_q;
  reg  [2:0]     seg_idx_q;
  reg  [2:0]     push_data;
  reg            push_valid;
  wire           push_ready;
  wire [SFW-1:0] new_scale_factor;
  wire [SFW-1:0] naf;
  wire           is_loss;
  wire           hdr_seg_en;
  wire [1:0]     mcls;

  // New scale factor from volume and target, allocation factor from activity and target
  assign new_scale_factor = (accumulated_code_volume > target_code_volume) ?
               scale_factor_reg + 1'b1 : scale_factor_reg;
  assign naf = total_activity_measure[SFW-1:0] ^ target_code_volume[SFW-1:0];
  assign is_loss = (mem_frame_marker == `JMS_SOF_LOSSLESS);
  assign mcls    = mode_class(mode);

  // Which header segment in index order is enabled
  assign hdr_seg_en = (seg_idx_q == `JMS_SEG_SOI) || (seg_idx_q == `JMS_SEG_EOI) ||
                      (seg_idx_q == `JMS_SEG_SOF && op_q != `JMS_MODE_TABLES) ||
                      (seg_idx_q == `JMS_SEG_APP && markers_en[`JMS_EN_APP]) ||
                      (seg_idx_q == `JMS_SEG_COM && markers_en[`JMS_EN_COM]) ||
                      (seg_idx_q == `JMS_SEG_DRI && markers_en[`JMS_EN_DRI] &&
                       op_q != `JMS_MODE_TABLES) ||
                      (seg_idx_q == `JMS_SEG_DQT && markers_en[`JMS_EN_DQT]) ||
                      (seg_idx_q == `JMS_SEG_DHT && markers_en[`JMS_EN_DHT]);

  // ------
  // Segment output FIFO
  // ------
  jms_fifo #(
    .WIDTH (3),
    .DEPTH (`JMS_FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (seg_out_data),
    .out_valid (seg_out_valid),
    .out_ready (seg_out_ready)
  );

  // Header walk pushes a segment code when enabled
  always @*
  begin
    push_data  = seg_idx_q;
    push_valid = 1'b0;
    if (st_q == S_HDR && hdr_seg_en && seg_idx_q != `JMS_SEG_EOI)
      push_valid = 1'b1;
    else if (st_q == S_TRAIL)
    begin
      push_data  = `JMS_SEG_EOI;
      push_valid = 1'b1;
    end
  end

  // ------
  // Sequencer
  // ------
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_q <= S_IDLE;
      op_q <= `JMS_MODE_COMP;
      rate_ctl_q <= 1'b0;
      dir_dec_q <= 1'b0;
      dir_known_q <= 1'b0;
      seg_idx_q <= 3'h0;
      busy <= 1'b0;
      lossless <= 1'b0;
      bad_mode <= 1'b0;
      pixel_active <= 1'b0;
      code_active <= 1'b0;
      dct_bypass <= 1'b0;
      quant_bypass <= 1'b0;
      dc_only <= 1'b0;
      point_transform <= 4'h0;
      huff_valid <= 1'b0;
      huff_enc_fmt <= 1'b0;
      quant_load <= 1'b0;
      huff_load <= 1'b0;
      seg_store_wr <= 1'b0;
      seg_store_type <= 3'h0;
      block_truncate <= 1'b0;
      block_budget <= 16'h0000;
      scale_factor_reg <= `JMS_SF_RESET;
      allocation_factor_reg <= {SFW{1'b0}};
      accumulated_code_volume <= {CVW{1'b0}};
      total_activity_measure <= {CVW{1'b0}};
    end
    else
    begin
      quant_load     <= 1'b0;
      huff_load      <= 1'b0;
      seg_store_wr   <= 1'b0;
      block_truncate <= 1'b0;
      if (host_sf_wr && st_q == S_IDLE)
        scale_factor_reg <= host_sf_data;
      point_transform <= (lossless || (st_q == S_FRAME && is_loss) ||
                          (in_marker_valid && in_frame_marker == `JMS_SOF_LOSSLESS)) ?
                         4'h0 : scan_point_transform;
      case (st_q)
        S_IDLE:
        begin
          if (go_wr)
          begin
            op_q     <= mode;
            bad_mode <= (mcls == 2'd2);
            if (mcls != 2'd2)
            begin
              busy <= 1'b1;
              if (dir_known_q && dir_dec_q != mcls[0])
                huff_valid <= 1'b0;
              dir_known_q   <= 1'b1;
              dir_dec_q     <= mcls[0];
              huff_enc_fmt  <= ~mcls[0];
              rate_ctl_q    <= (mode == `JMS_MODE_COMP_BRC);
              accumulated_code_volume <= {CVW{1'b0}};
              total_activity_measure  <= {CVW{1'b0}};
              seg_idx_q     <= 3'h0;
              st_q          <= S_FRAME;
            end
          end
        end
        S_FRAME:
        begin
          // Decide direction and baseline or lossless
          if (op_q == `JMS_MODE_PRE_ENC || op_q == `JMS_MODE_PRE_DEC)
            st_q <= S_LOAD;
          else if (mode_class(op_q) == 2'd1)
          begin
            st_q         <= S_EXP;
            lossless     <= 1'b0;
            quant_bypass <= 1'b0;
            pixel_active <= 1'b1;
            code_active  <= 1'b1;
            dc_only      <= (op_q == `JMS_MODE_PREVIEW);
            dct_bypass   <= (op_q == `JMS_MODE_PREVIEW);
          end
          else
          begin
            lossless     <= is_loss;
            dct_bypass   <= is_loss;
            quant_bypass <= is_loss;
            // Baseline-only encode modes on a lossless frame abort
            if ((is_loss && base_only(op_q)) ||
                (is_loss && (sample_precision < `JMS_LOSSLESS_MINP ||
                             sample_precision > `JMS_LOSSLESS_MAXP)))
            begin
              bad_mode <= 1'b1;
              busy     <= 1'b0;
              st_q     <= S_IDLE;
            end
            else if (op_q == `JMS_MODE_STAT || op_q == `JMS_MODE_AUTO_BRC)
            begin
              st_q <= S_STAT;
              if (markers_en[`JMS_EN_DQT])
                quant_load <= 1'b1;
              pixel_active <= 1'b1;
            end
            else
              st_q <= S_HDR;
          end
        end
        S_HDR:
        begin
          // Walk segment codes in fixed order
          if (!hdr_seg_en || push_ready || seg_idx_q == `JMS_SEG_EOI)
          begin
            if (seg_idx_q == `JMS_SEG_DQT && hdr_seg_en)
              quant_load <= 1'b1;
            if (seg_idx_q == `JMS_SEG_DHT && hdr_seg_en)
            begin
              huff_load  <= 1'b1;
              huff_valid <= 1'b1;
            end
            if (seg_idx_q == `JMS_SEG_SOF || seg_idx_q == `JMS_SEG_EOI)
            begin
              if (op_q == `JMS_MODE_TABLES)
                st_q <= S_TRAIL;
              else
              begin
                st_q         <= S_CODE;
                pixel_active <= 1'b1;
                code_active  <= 1'b1;
              end
            end
            else
              seg_idx_q <= seg_idx_q + 3'h1;
          end
        end
        S_STAT:
        begin
          // Encode without code output
          if (block_done)
          begin
            accumulated_code_volume <= accumulated_code_volume + {{(CVW-16){1'b0}}, block_bits};
            total_activity_measure  <= total_activity_measure + {{(CVW-16){1'b0}}, block_activity};
          end
          if (image_done)
          begin
            scale_factor_reg      <= new_scale_factor;
            allocation_factor_reg <= naf;
            pixel_active          <= 1'b0;
            if (op_q == `JMS_MODE_AUTO_BRC)
            begin
              rate_ctl_q    <= 1'b1;
              quant_load    <= 1'b1;
              st_q          <= S_HDR;
            end
            else
            begin
              busy <= 1'b0;
              st_q <= S_IDLE;
            end
          end
        end
        S_CODE:
        begin
          // Block budget before each block, truncation while coding
          if (rate_ctl_q)
          begin
            block_budget <= block_activity ^ allocation_factor_reg[15:0];
            if (({{(CVW-16){1'b0}}, block_bits} > {{(CVW-16){1'b0}}, block_budget}) ||
                ({{(CVW-16){1'b0}}, block_bits} > max_block_code_volume))
              block_truncate <= 1'b1;
          end
          if (image_done)
          begin
            scale_factor_reg <= new_scale_factor;
            pixel_active     <= 1'b0;
            code_active      <= 1'b0;
            st_q             <= S_TRAIL;
          end
          if (block_done)
            accumulated_code_volume <= accumulated_code_volume + {{(CVW-16){1'b0}}, block_bits};
        end
        S_TRAIL:
        begin
          if (push_ready)
          begin
            busy <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_LOAD:
        begin
          // Preload with interfaces idle
          quant_load   <= markers_en[`JMS_EN_PRELOAD_QUANT_TABLES];
          huff_load    <= markers_en[`JMS_EN_PRELOAD_HUFFMAN_TABLES];
          if (markers_en[`JMS_EN_PRELOAD_HUFFMAN_TABLES])
            huff_valid <= 1'b1;
          pixel_active <= 1'b0;
          code_active  <= 1'b0;
          busy         <= 1'b0;
          st_q         <= S_IDLE;
        end
        S_EXP:
        begin
          if (in_marker_valid && in_frame_marker == `JMS_SOF_LOSSLESS)
          begin
            lossless     <= 1'b1;
            dct_bypass   <= 1'b1;
            quant_bypass <= 1'b1;
          end
          else if (in_marker_valid && in_frame_marker == `JMS_SOF_BASE)
            lossless <= 1'b0;
          if (seg_in_valid)
          begin
            seg_store_wr   <= 1'b1;
            seg_store_type <= seg_in_type;
            if (seg_in_type == `JMS_SEG_DQT)
              quant_load <= 1'b1;
            if (seg_in_type == `JMS_SEG_DHT)
            begin
              huff_load  <= 1'b1;
              huff_valid <= 1'b1;
            end
          end
          if (image_done)
          begin
            pixel_active <= 1'b0;
            code_active  <= 1'b0;
            dc_only      <= 1'b0;
            busy         <= 1'b0;
            st_q         <= S_IDLE;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule // jms_sequencer

//--- verification/jms_host_model.sv
// Far-side model: drains segment codes from the sequencer FIFO.
// Assumes one clock; ready changes only at the falling edge.
`timescale 1ns/100ps
module jms_host_model (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        clr,
  input  wire        stall,
  input  wire [2:0]  seg_out_data,
  input  wire        seg_out_valid,
  output reg         seg_out_ready = 1'b1,
  output reg  [7:0]  n = 8'h00,
  output reg  [23:0] c = 24'h000000
);
  integer seed = 32'h5A5A0001;

  // Random stalls back up the FIFO
  always @(negedge sys_clk)
    seg_out_ready <= stall ? $random(seed) : 1'b1;

  // Count and shift in every accepted code
  always @(posedge sys_clk)
    if (!rstn || clr)
    begin
      n <= 8'h00;
      c <= 24'h000000;
    end
    else if (seg_out_valid && seg_out_ready)
    begin
      n <= n + 8'h01;
      c <= {c[20:0], seg_out_data};
    end
endmodule // jms_host_model

//--- verification/jms_seq_checker.sv
// Port assertions for the mode sequencer.
// Assumes a bind into jms_sequencer; one clock, sync active-low reset.
`timescale 1ns/100ps
module jms_seq_checker #(
  parameter SFW = 16
) (
  input wire           sys_clk,
  input wire           rstn,
  input wire [3:0]     mode,
  input wire           go_wr,
  input wire [SFW-1:0] host_sf_data,
  input wire           host_sf_wr,
  input wire [15:0]    mem_frame_marker,
  input wire [3:0]     sample_precision,
  input wire [2:0]     seg_out_data,
  input wire           seg_out_valid,
  input wire           seg_out_ready,
  input wire           busy,
  input wire           lossless,
  input wire           bad_mode,
  input wire           pixel_active,
  input wire           code_active,
  input wire           dct_bypass,
  input wire           quant_bypass,
  input wire [3:0]     point_transform,
  input wire           block_truncate,
  input wire [SFW-1:0] scale_factor_reg
);
  reg  [3:0] mode_q;
  wire       ok = mode inside {[4'h0:4'h5], [4'h8:4'hA]};
  wire       go = go_wr && !busy;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Mode of the running operation
  always @(posedge sys_clk)
    if (!rstn)
      mode_q <= 4'h0;
    else if (go)
      mode_q <= mode;

  // ------
  // Assertions
  // ------
  property p_start; go && ok |=> busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_badm; go && !ok |-> ##[1:2] (bad_mode && !busy); endproperty
  a_badm: assert property (p_badm) else $error("bad code taken");
  property p_base; go && mode inside {4'h1, 4'h2, 4'h3} && mem_frame_marker == 16'hFFC3 |-> ##[1:4] bad_mode;
  endproperty
  a_base: assert property (p_base) else $error("baseline mode on lossless");
  property p_loss; go && mode == 4'h0 && mem_frame_marker == 16'hFFC3 && sample_precision inside {[4'h2:4'hC]}
    |-> ##[1:3] lossless; endproperty
  a_loss: assert property (p_loss) else $error("lossless not chosen");
  property p_byp; busy && lossless |-> dct_bypass && quant_bypass; endproperty
  a_byp: assert property (p_byp) else $error("no bypass");
  property p_pt; busy && lossless |-> point_transform == 4'h0; endproperty
  a_pt: assert property (p_pt) else $error("point transform used");
  property p_rst; $rose(rstn) |-> scale_factor_reg == 16'h0100 && !busy; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_sfwr; host_sf_wr && !busy && !go_wr |=> scale_factor_reg == $past(host_sf_data); endproperty
  a_sfwr: assert property (p_sfwr) else $error("scale write lost");
  property p_idle; busy && mode_q inside {4'h4, 4'h5, 4'hA} |-> !pixel_active; endproperty
  a_idle: assert property (p_idle) else $error("pixels active");
  property p_cbuf; busy && mode_q inside {4'h5, 4'hA} |-> !code_active; endproperty
  a_cbuf: assert property (p_cbuf) else $error("code buffer active");
  property p_fifo; seg_out_valid && !seg_out_ready |=> seg_out_valid && $stable(seg_out_data); endproperty
  a_fifo: assert property (p_fifo) else $error("code dropped");
  property p_trunc; block_truncate |-> mode_q inside {4'h1, 4'h3}; endproperty
  a_trunc: assert property (p_trunc) else $error("stray truncation");
endmodule // jms_seq_checker

bind jms_sequencer jms_seq_checker #(.SFW(SFW)) u_chk (.*);

//--- verification/jms_sequencer_tb_top.sv
// Self-checking bench for the mode sequencer.
// Assumes jms_host_model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "jms_map.vh"
module jms_sequencer_tb_top;
  reg         sys_clk = 1'b0, rstn = 1'b0, go_wr = 1'b0, host_sf_wr = 1'b0, in_marker_valid = 1'b0;
  reg         block_done = 1'b0, image_done = 1'b0, seg_in_valid = 1'b0, clr = 1'b0, stall = 1'b1;
  reg  [3:0]  mode = 4'h0, sample_precision = 4'h8, scan_point_transform = 4'h3;
  reg  [15:0] host_sf_data = 16'h0000, mem_frame_marker = 16'hFFC0, in_frame_marker = 16'hFFC0;
  reg  [15:0] block_activity = 16'h0000, block_bits = 16'h0000;
  reg  [6:0]  markers_en = 7'h00;
  reg  [23:0] target_code_volume = 24'hFFFFFF, max_block_code_volume = 24'hFFFFFF;
  reg  [2:0]  seg_in_type = 3'h0;
  wire [2:0]  seg_out_data, seg_store_type;
  wire        seg_out_valid, seg_out_ready, busy, lossless, bad_mode, pixel_active, code_active;
  wire        dct_bypass, quant_bypass, dc_only, huff_valid, huff_enc_fmt, quant_load, huff_load;
  wire        seg_store_wr, block_truncate;
  wire [3:0]  point_transform;
  wire [15:0] block_budget, scale_factor_reg, allocation_factor_reg;
  wire [23:0] accumulated_code_volume, total_activity_measure, got_c;
  wire [7:0]  got_n;
  integer     seed = 32'hD9EA2363;
  integer     fails = 0, checks = 0, nq, nh, ns, ntr, i, j, k;
  reg  [31:0] vol, act, e;
  reg  [15:0] sf;
  reg         ls_seen, dc_seen;

  jms_sequencer u_dut (.*);
  jms_host_model u_host (.sys_clk(sys_clk), .rstn(rstn), .clr(clr), .stall(stall), .seg_out_data(seg_out_data),
    .seg_out_valid(seg_out_valid), .seg_out_ready(seg_out_ready), .n(got_n), .c(got_c));

  // Clock
  initial
    forever #5 sys_clk = ~sys_clk;

  // Strobe counters
  always @(posedge sys_clk)
  begin
    nq = nq + quant_load;
    nh = nh + huff_load;
    ns = ns + seg_store_wr;
    ntr = ntr + block_truncate;
  end

  // ------
  // Helpers
  // ------
  // Expected count and codes: SOI, enabled segments except DRI when tables only, SOF unless tables only, EOI
  function [31:0] expc(input [6:0] me, input t);
    integer b;
    begin
      expc = 32'h01000000;
      for (b = 0; b < 6; b = b + 1)
        if ((b == 5) ? !t : (me[b] && !(t && b == 2)))
          expc = {expc[31:24] + 8'h01, expc[20:0], b[2:0] + 3'h1};
      expc = {expc[31:24] + 8'h01, expc[20:0], 3'h7};
    end
  endfunction

  task chk(input [31:0] got, input [31:0] exp, input string what);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  task finish_test;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  // One operation: launch, stream events, wait for idle
  task op(input [3:0] m, input integer ni);
  begin
    nq = 0; nh = 0; ns = 0; ntr = 0; vol = 0; act = 0;
    clr = 1'b1;
    mode = m;
    go_wr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    go_wr = 1'b0;
    if (m == `JMS_MODE_EXPAND || m == `JMS_MODE_PREVIEW)
    begin
      @(negedge sys_clk);
      in_marker_valid = 1'b1;
      @(negedge sys_clk);
      in_marker_valid = 1'b0;
      for (i = 0; i < 2; i = i + 1)
      begin
        seg_in_type = `JMS_SEG_DQT;
        seg_in_valid = 1'b1;
        @(negedge sys_clk);
        seg_in_valid = 1'b0;
        @(negedge sys_clk);
      end
    end
    repeat (4) @(negedge sys_clk);
    ls_seen = lossless;
    dc_seen = dc_only;
    for (k = 0; k < ni; k = k + 1)
    begin
      for (i = 0; i < 99 && pixel_active !== 1'b1; i = i + 1)
        @(negedge sys_clk);
      chk(i < 99, 1'b1, "no pixels");
      for (i = 0; i < 4; i = i + 1)
      begin
        block_activity = $random(seed);
        block_bits = $random(seed) & 32'h3FF;
        vol = vol + block_bits;
        act = act + block_activity;
        block_done = 1'b1;
        @(negedge sys_clk);
        block_done = 1'b0;
        @(negedge sys_clk);
      end
      image_done = 1'b1;
      @(negedge sys_clk);
      image_done = 1'b0;
      repeat (8) @(negedge sys_clk);
    end
    for (i = 0; i < 400 && (busy !== 1'b0 || seg_out_valid !== 1'b0); i = i + 1)
      @(negedge sys_clk);
    chk(i < 400, 1'b1, "operation hung");
    if (i >= 400)
      finish_test;
    repeat (2) @(negedge sys_clk);
    $display("op %h done", m);
  end
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk(scale_factor_reg, 16'h0100, "sf reset");
    sf = $random(seed);
    host_sf_data = sf;
    host_sf_wr = 1'b1;
    @(negedge sys_clk);
    host_sf_wr = 1'b0;
    @(negedge sys_clk);
    chk(scale_factor_reg, sf, "sf write");
    // Baseline compression, target out of reach
    for (j = 0; j < 3; j = j + 1)
    begin
      markers_en = $random(seed) & 32'h1F;
      op(`JMS_MODE_COMP, 1);
      e = expc(markers_en, 1'b0);
      chk(got_n, e[31:24], "seg count");
      chk(got_c, e[23:0], "seg order");
      chk(scale_factor_reg, sf, "sf kept");
    end
    // Lossless compression, target exceeded
    mem_frame_marker = `JMS_SOF_LOSSLESS;
    sample_precision = `JMS_LOSSLESS_MAXP;
    target_code_volume = 24'h000000;
    op(`JMS_MODE_COMP, 1);
    sf = sf + 16'h0001;
    chk(ls_seen, 1'b1, "lossless");
    chk(scale_factor_reg, sf, "sf new");
    sample_precision = 4'h1;
    op(`JMS_MODE_COMP, 0);
    chk(bad_mode, 1'b1, "precision");
    sample_precision = 4'h8;
    op(`JMS_MODE_STAT, 0);
    chk(bad_mode, 1'b1, "stat lossless");
    mem_frame_marker = `JMS_SOF_BASE;
    // Statistical pass
    op(`JMS_MODE_STAT, 1);
    sf = sf + 16'h0001;
    chk(accumulated_code_volume, vol, "volume");
    chk(total_activity_measure, act, "activity");
    chk(scale_factor_reg, sf, "sf stat");
    chk(allocation_factor_reg, act[15:0] ^ target_code_volume[15:0], "alloc");
    chk(got_n, 0, "no code");
    // Rate-controlled passes, DQT enabled first
    markers_en = 7'h08;
    max_block_code_volume = 24'h000001;
    op(`JMS_MODE_COMP_BRC, 1);
    chk(ntr != 0, 1'b1, "truncation");
    op(`JMS_MODE_AUTO_BRC, 2);
    e = expc(markers_en, 1'b0);
    chk(got_n, e[31:24], "auto segs");
    // Tables only and preloads
    markers_en = 7'h1F;
    op(`JMS_MODE_TABLES, 0);
    e = expc(markers_en, 1'b1);
    chk(got_c, e[23:0], "tables only");
    chk(got_n, e[31:24], "tables count");
    markers_en = 7'h60;
    op(`JMS_MODE_PRE_ENC, 0);
    chk({nq[7:0], nh[7:0], huff_enc_fmt, huff_valid}, {8'd1, 8'd1, 2'b11}, "enc preload");
    markers_en = 7'h20;
    op(`JMS_MODE_PRE_DEC, 0);
    chk({nq[7:0], nh[7:0], huff_valid}, {8'd1, 8'd0, 1'b0}, "dec preload");
    // Expansion and preview
    in_frame_marker = `JMS_SOF_LOSSLESS;
    op(`JMS_MODE_EXPAND, 1);
    chk({ls_seen, ns[7:0], seg_store_type}, {1'b1, 8'd2, `JMS_SEG_DQT}, "expand");
    in_frame_marker = `JMS_SOF_BASE;
    op(`JMS_MODE_PREVIEW, 1);
    chk(dc_seen, 1'b1, "preview");
    // Unused mode codes
    for (j = 6; j < 16; j = j + 1)
      if (j < 8 || j > 10)
      begin
        op(j[3:0], 0);
        chk(bad_mode, 1'b1, "bad code");
      end
    finish_test;
  end
endmodule // jms_sequencer_tb_top
